// ===== hw/light_threshold_interrupt_flags.sv
`timescale 1ns/1ns
`include "light_thr_defs.svh"
module light_threshold_interrupt_flags (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// measurement engine
	input  wire logic        conv_done,
	input  wire logic [15:0] conv_result,
	output logic [1:0]       conv_mode,
	// alert response from the bus logic
	input  wire logic        alert_resp,
	output logic             alert_claim,
	// open-drain interrupt pin
	output logic             int_pin_o,
	output logic             int_pin_oe,
	// system interrupt
	output logic             irq
);

	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	light_thr_pkg::flags_s s_q;
	light_thr_pkg::flags_s s_d;
	light_thr_pkg::cmp_e   outcome;
	logic                  cfg_rd;
	logic                  cfg_wr;
	logic                  eoc;
	logic [3:0]            need;
	logic [2:0]            stat_clr;
	logic                  mask_we;
	logic [2:0]            irq_stat;
	logic [2:0]            irq_mask;
	logic [31:0]           cfg_word;

	thr_event_if ev ();

	assign cfg_rd  = reg_rd && reg_hit(reg_addr, `REG_CFG);
	assign cfg_wr  = reg_wr && reg_hit(reg_addr, `REG_CFG);
	assign mask_we = reg_wr && reg_hit(reg_addr, `REG_IRQ_MASK);
	assign stat_clr = (reg_wr && reg_hit(reg_addr, `REG_IRQ_STAT))
		? reg_wdata[2:0] : 3'h0;

	// end-of-conversion variant overrides the normal flag tables
	assign eoc = (s_q.low[`LO_TOP_MSB:`LO_TOP_LSB] == `EOC_CODE);

	// ****************************************************************
	// limit comparison and fault run
	// ****************************************************************
	// with high below low both may hold; high takes precedence
	always_comb begin
		if (conv_result > s_q.high) begin
			outcome = light_thr_pkg::CMP_HIGH;
		end else if (conv_result < s_q.low) begin
			outcome = light_thr_pkg::CMP_LOW;
		end else begin
			outcome = light_thr_pkg::CMP_NONE;
		end
	end

	assign need = {2'b00, s_q.fc} + `RUN_ONE;

	fault_run_counter u_run (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.conv_done (conv_done),
		.outcome   (outcome),
		.need      (need),
		.ev        (ev.src)
	);

	irq_sticky u_irq (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.ev         (ev.dst),
		.stat_clr   (stat_clr),
		.mask_we    (mask_we),
		.mask_wdata (reg_wdata[2:0]),
		.stat       (irq_stat),
		.mask       (irq_mask),
		.irq        (irq)
	);

	// ****************************************************************
	// configuration word as software sees it
	// ****************************************************************
	always_comb begin
		cfg_word = 32'h0;
		cfg_word[`CFG_FC_MSB:`CFG_FC_LSB]     = s_q.fc;
		cfg_word[`CFG_POL_BIT]                = s_q.interrupt_polarity_select;
		cfg_word[`CFG_LATCH_BIT]              = s_q.latch;
		cfg_word[`CFG_FL_BIT]                 = s_q.fl;
		cfg_word[`CFG_FH_BIT]                 = s_q.fh;
		cfg_word[`CFG_CR_BIT]                 = s_q.cr;
		cfg_word[`CFG_MODE_MSB:`CFG_MODE_LSB] = s_q.mode;
	end

	// ****************************************************************
	// flag engine
	// ****************************************************************
	// clears are applied first and sets last, so a conversion that
	// finishes in the clearing cycle is never lost
	always_comb begin
		s_d             = s_q;
		s_d.rdata       = 32'h0;
		s_d.alert_claim = 1'b0;

		// clearing accesses
		if (cfg_rd) begin
			s_d.cr = 1'b0;
			if (s_q.latch) begin
				s_d.fh     = 1'b0;
				s_d.fl     = 1'b0;
				s_d.active = 1'b0;
			end else if (eoc) begin
				s_d.active = 1'b0;
			end
			// transparent: flags follow the light only
		end
		if (cfg_wr) begin
			s_d.fc    = reg_wdata[`CFG_FC_MSB:`CFG_FC_LSB];
			s_d.interrupt_polarity_select   = reg_wdata[`CFG_POL_BIT];
			s_d.latch = reg_wdata[`CFG_LATCH_BIT];
			s_d.mode  = reg_wdata[`CFG_MODE_MSB:`CFG_MODE_LSB];
			// shutdown code touches no flag
			if (reg_wdata[`CFG_MODE_MSB:`CFG_MODE_LSB]
				!= `MODE_SHUTDOWN) begin
				s_d.cr = 1'b0;
				if (!s_q.latch && eoc) begin
					s_d.active = 1'b0;
				end
			end
		end
		if (alert_resp && s_q.latch && s_q.active) begin
			s_d.active      = 1'b0;
			s_d.alert_claim = 1'b1;
		end
		if (reg_wr && reg_hit(reg_addr, `REG_HIGH)) begin
			s_d.high = reg_wdata[`LIM_MSB:0];
		end
		if (reg_wr && reg_hit(reg_addr, `REG_LOW)) begin
			s_d.low = reg_wdata[`LIM_MSB:0];
		end

		// conversion results
		if (conv_done) begin
			s_d.result = conv_result;
		end
		if (ev.done) begin
			s_d.cr = 1'b1;
			if (eoc) begin
				s_d.active = 1'b1;
			end
		end
		if (ev.trig_high) begin
			s_d.fh     = 1'b1;
			s_d.active = 1'b1;
			if (!s_q.latch) begin
				s_d.fl = 1'b0;
			end
		end
		if (ev.trig_low) begin
			s_d.fl = 1'b1;
			if (s_q.latch) begin
				s_d.active = 1'b1;
			end else begin
				s_d.fh = 1'b0;
				if (!eoc) begin
					s_d.active = 1'b0;
				end
			end
		end

		// pin pulled low exactly when active differs from polarity
		s_d.pin_oe = s_d.active ^ s_d.interrupt_polarity_select;

		// read data, one cycle after the strobe
		if (reg_rd) begin
			if (reg_hit(reg_addr, `REG_CFG)) begin
				s_d.rdata = cfg_word;
			end else if (reg_hit(reg_addr, `REG_HIGH)) begin
				s_d.rdata = {16'h0, s_q.high};
			end else if (reg_hit(reg_addr, `REG_LOW)) begin
				s_d.rdata = {16'h0, s_q.low};
			end else if (reg_hit(reg_addr, `REG_IRQ_STAT)) begin
				s_d.rdata = {29'h0, irq_stat};
			end else if (reg_hit(reg_addr, `REG_IRQ_MASK)) begin
				s_d.rdata = {29'h0, irq_mask};
			end else if (reg_hit(reg_addr, `REG_RESULT)) begin
				s_d.rdata = {16'h0, s_q.result};
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q.latch       <= `LATCH_RESET;
			s_q.interrupt_polarity_select         <= `POL_RESET;
			s_q.fc          <= `FC_RESET;
			s_q.mode        <= `MODE_RESET;
			s_q.high        <= `HIGH_RESET;
			s_q.low         <= `LOW_RESET;
			s_q.result      <= 16'h0;
			s_q.fh          <= 1'b0;
			s_q.fl          <= 1'b0;
			s_q.cr          <= 1'b0;
			s_q.active      <= 1'b0;
			s_q.pin_oe      <= 1'b0;
			s_q.alert_claim <= 1'b0;
			s_q.rdata       <= 32'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// open drain: the driven level is always low
	assign int_pin_o   = 1'b0;
	assign int_pin_oe  = s_q.pin_oe;
	assign reg_rdata   = s_q.rdata;
	assign conv_mode   = s_q.mode;
	assign alert_claim = s_q.alert_claim;
endmodule

// ===== hw/light_thr_defs.svh
`ifndef LIGHT_THR_DEFS_SVH
`define LIGHT_THR_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define REG_CFG        8'h00
`define REG_HIGH       8'h04
`define REG_LOW        8'h08
`define REG_IRQ_STAT   8'h0c
`define REG_IRQ_MASK   8'h10
`define REG_RESULT     8'h14

// ****************************************************************
// configuration word fields
// ****************************************************************
`define CFG_FC_LSB     0
`define CFG_FC_MSB     1
`define CFG_POL_BIT    3
`define CFG_LATCH_BIT  4
`define CFG_FL_BIT     5
`define CFG_FH_BIT     6
`define CFG_CR_BIT     7
`define CFG_MODE_LSB   9
`define CFG_MODE_MSB   10

// ****************************************************************
// limit fields and codes
// ****************************************************************
`define LIM_MSB        15
`define LO_TOP_MSB     15
`define LO_TOP_LSB     14
`define EOC_CODE       2'h3
`define MODE_SHUTDOWN  2'h0

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define IRQ_HIGH_BIT   0
`define IRQ_LOW_BIT    1
`define IRQ_DONE_BIT   2

// ****************************************************************
// reset values
// ****************************************************************
`define LATCH_RESET    1'b1
`define POL_RESET      1'b0
`define FC_RESET       2'h0
`define MODE_RESET     2'h0
`define HIGH_RESET     16'hffff
`define LOW_RESET      16'h0000
`define MASK_RESET     3'h0

// ****************************************************************
// fault run counter
// ****************************************************************
`define RUN_MAX        4'hf
`define RUN_ONE        4'h1

`endif

// ===== hw/light_thr_pkg.sv
package light_thr_pkg;

	typedef enum logic [1:0] {
		CMP_NONE = 2'b00,
		CMP_HIGH = 2'b01,
		CMP_LOW  = 2'b10
	} cmp_e;

	typedef struct packed {
		cmp_e       last;
		logic [3:0] run;
	} run_s;

	typedef struct packed {
		logic [2:0] stat;
		logic [2:0] mask;
		logic       irq;
	} irq_s;

	typedef struct packed {
		logic        latch;
		logic        interrupt_polarity_select;
		logic [1:0]  fc;
		logic [1:0]  mode;
		logic [15:0] high;
		logic [15:0] low;
		logic [15:0] result;
		logic        fh;
		logic        fl;
		logic        cr;
		logic        active;
		logic        pin_oe;
		logic        alert_claim;
		logic [31:0] rdata;
	} flags_s;

endpackage

// ===== hw/thr_event_if.sv
`timescale 1ns/1ns
interface thr_event_if;
	logic done;
	logic trig_high;
	logic trig_low;

	modport src (output done, output trig_high, output trig_low);
	modport dst (input done, input trig_high, input trig_low);
endinterface

// ===== hw/fault_run_counter.sv
`timescale 1ns/1ns
`include "light_thr_defs.svh"
module fault_run_counter (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_b,
	// finished conversion
	input  wire logic                conv_done,
	input  wire light_thr_pkg::cmp_e outcome,
	input  wire logic [3:0]          need,
	// qualified events
	thr_event_if.src                 ev
);
	light_thr_pkg::run_s s_q;
	light_thr_pkg::run_s s_d;
	logic [3:0]          run_next;

	always_comb begin
		s_d = s_q;
		// a changed outcome restarts the run
		if (outcome != s_q.last) begin
			run_next = `RUN_ONE;
		end else if (s_q.run != `RUN_MAX) begin
			run_next = s_q.run + `RUN_ONE;
		end else begin
			run_next = s_q.run;
		end
		if (conv_done) begin
			s_d.last = outcome;
			s_d.run  = run_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q.last <= light_thr_pkg::CMP_NONE;
			s_q.run  <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// every conversion of a long enough run keeps asserting
	assign ev.done      = conv_done;
	assign ev.trig_high = conv_done && outcome == light_thr_pkg::CMP_HIGH
		&& run_next >= need;
	assign ev.trig_low  = conv_done && outcome == light_thr_pkg::CMP_LOW
		&& run_next >= need;
endmodule

// ===== hw/irq_sticky.sv
`timescale 1ns/1ns
`include "light_thr_defs.svh"
module irq_sticky (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// events
	thr_event_if.dst        ev,
	// software access
	input  wire logic [2:0] stat_clr,
	input  wire logic       mask_we,
	input  wire logic [2:0] mask_wdata,
	// state
	output logic [2:0]      stat,
	output logic [2:0]      mask,
	output logic            irq
);
	light_thr_pkg::irq_s s_q;
	light_thr_pkg::irq_s s_d;
	logic [2:0]          ev_vec;

	always_comb begin
		ev_vec = 3'h0;
		ev_vec[`IRQ_HIGH_BIT] = ev.trig_high;
		ev_vec[`IRQ_LOW_BIT]  = ev.trig_low;
		ev_vec[`IRQ_DONE_BIT] = ev.done;
		s_d = s_q;
		// set after clear: an event in the clearing cycle survives
		s_d.stat = (s_q.stat & ~stat_clr) | ev_vec;
		if (mask_we) begin
			s_d.mask = mask_wdata;
		end
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q.stat <= 3'h0;
			s_q.mask <= `MASK_RESET;
			s_q.irq  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stat = s_q.stat;
	assign mask = s_q.mask;
	assign irq  = s_q.irq;
endmodule

// ===== dv/light_thr_properties.sv
`timescale 1ns/1ns
module light_thr_properties (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_b,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// conversion and alert
	input wire logic        conv_done,
	input wire logic [15:0] conv_result,
	input wire logic [1:0]  conv_mode,
	input wire logic        alert_resp,
	input wire logic        alert_claim,
	// pins
	input wire logic        int_pin_o,
	input wire logic        int_pin_oe,
	input wire logic        irq
);
	logic [1:0] wmode;
	assign wmode = reg_wdata[10:9];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ****************
	// steps
	// ****************
	sequence s_rd_cfg;
		reg_rd && reg_addr == 8'h00 && !conv_done;
	endsequence
	sequence s_gap;
		!reg_rd && !reg_wr && !conv_done;
	endsequence
	sequence s_wr_run;
		reg_wr && reg_addr == 8'h00 && wmode != 2'h0 && !conv_done;
	endsequence
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_second_read: assert property (
		s_rd_cfg ##1 s_rd_cfg |=> !reg_rdata[7])
		else $error("ready survived a read");
	a_done_ready: assert property (
		conv_done ##1 s_gap ##1 s_rd_cfg |=> reg_rdata[7])
		else $error("ready not set by conversion");
	a_write_clears: assert property (
		s_wr_run ##1 s_gap ##1 s_rd_cfg |=> !reg_rdata[7])
		else $error("ready survived run write");
	a_mode_out: assert property (
		reg_wr && reg_addr == 8'h00 |=> conv_mode == $past(wmode))
		else $error("mode output wrong");
	a_quiet_hold: assert property (
		!conv_done && !reg_wr && !reg_rd && !alert_resp
		|=> $stable(int_pin_oe) && $stable(irq))
		else $error("pin moved with no cause");
	a_claim_cause: assert property (
		alert_claim |-> $past(alert_resp))
		else $error("claim without alert");
	a_claim_once: assert property (
		alert_claim |=> !alert_claim)
		else $error("claim longer than a cycle");
	a_pin_low: assert property (
		int_pin_o == 1'b0)
		else $error("pin drives high");
endmodule

bind light_threshold_interrupt_flags light_thr_properties u_props (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .conv_done(conv_done),
	.conv_result(conv_result), .conv_mode(conv_mode),
	.alert_resp(alert_resp), .alert_claim(alert_claim),
	.int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));

// ===== dv/int_line_pullup.sv
`timescale 1ns/1ns
module int_line_pullup (
	// open-drain pin
	input wire logic int_pin_o,
	input wire logic int_pin_oe,
	// host view
	output logic     pin_level
);
	// released line floats up through the host resistor
	assign pin_level = int_pin_oe ? int_pin_o : 1'b1;
endmodule

// ===== dv/light_threshold_interrupt_flags_tb.sv
`timescale 1ns/1ns
module light_threshold_interrupt_flags_tb;
	logic        clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
	logic        conv_done = 0, alert_resp = 0, rd_d = 0, pin_level;
	logic [15:0] conv_result = 16'h0, hi = 16'h1000, lo = 16'h0100, r16;
	logic [1:0]  conv_mode, fc = 2'h0, mode = 2'h0;
	logic        lat = 1, interrupt_polarity_select = 0, alert_claim, int_pin_o, int_pin_oe, irq;
	logic [31:0] exp_q[$];
	int          seed = 21, bad_count = 0, comparisons = 0;
	always #50 clk_sys = ~clk_sys;
	light_threshold_interrupt_flags DUT (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
		.conv_result(conv_result), .conv_mode(conv_mode),
		.alert_resp(alert_resp), .alert_claim(alert_claim),
		.int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));
	int_line_pullup host (.int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
		.pin_level(pin_level));
	// ****************
	// helpers
	// ****************
	function logic [31:0] cw(input logic h, input logic l, input logic c);
		cw = {21'h0, mode, 1'b0, c, h, l, lat, interrupt_polarity_select, 1'b0, fc};
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %0t saw %h want %h", $time, s, e);
		end
	endtask
	task conclude;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// held strobe repeats the access, one per cycle
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input int n);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		repeat (n) @(posedge clk_sys);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(0, a, 32'h0, 1);
	endtask
	// k: 1 above high limit, 2 below low limit, 0 in between
	task conv(input logic [1:0] k);
		@(posedge clk_sys);
		rv = $random(seed);
		r16 = {8'h0, rv[7:0]};
		conv_done <= 1;
		conv_result <= k == 2'h1 ? hi + 16'h1 + r16 :
			k == 2'h2 ? lo - 16'h1 - r16 : lo + r16;
		@(posedge clk_sys);
		conv_done <= 0;
		#1;
	endtask
	task pin(input logic l, input logic i);
		chk(32'(pin_level), 32'(l));
		chk(32'(irq), 32'(i));
	endtask
	task alert(input logic e);
		@(posedge clk_sys);
		alert_resp <= 1;
		@(posedge clk_sys);
		alert_resp <= 0;
		#1 chk(32'(alert_claim), 32'(e));
	endtask
	// ****************
	// read data monitor
	// ****************
	always @(posedge clk_sys) begin
		rd_d <= reg_rd;
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
	end
	initial begin
		#(100 * 3000);
		bad_count++;
		conclude();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1;
		rd(8'h00, cw(0, 0, 0));
		rd(8'h04, 32'h0000ffff);
		rd(8'h08, 32'h0);
		rd(8'h18, 32'h0);
		pin(1, 0);
		acc(1, 8'h04, {16'h0, hi}, 1);
		acc(1, 8'h08, {16'h0, lo}, 1);
		acc(1, 8'h10, 32'h1, 1);
		fc = 2'h1;
		mode = 2'h1;
		acc(1, 8'h00, cw(0, 0, 0), 1);
		chk(32'(conv_mode), 32'h1);
		$display("test 1 done");
		conv(2'h1);
		conv(2'h2);
		conv(2'h1);
		pin(1, 0);
		conv(2'h1);
		pin(0, 1);
		exp_q.push_back(cw(1, 0, 1));
		exp_q.push_back(cw(0, 0, 0));
		acc(0, 8'h00, 32'h0, 2);
		pin(1, 1);
		acc(1, 8'h0c, 32'h7, 1);
		pin(1, 0);
		$display("test 2 done");
		conv(2'h2);
		conv(2'h2);
		pin(0, 0);
		alert(1);
		pin(1, 0);
		rd(8'h0c, 32'h6);
		rd(8'h00, cw(0, 1, 1));
		conv(2'h0);
		mode = 2'h0;
		acc(1, 8'h00, cw(0, 0, 0), 1);
		chk(32'(conv_mode), 32'h0);
		rd(8'h00, cw(0, 0, 1));
		conv(2'h0);
		mode = 2'h1;
		acc(1, 8'h00, cw(0, 0, 0), 1);
		rd(8'h00, cw(0, 0, 0));
		$display("test 3 done");
		lat = 0;
		interrupt_polarity_select = 1;
		fc = 2'h0;
		acc(1, 8'h00, cw(0, 0, 0), 1);
		pin(0, 0);
		conv(2'h1);
		pin(1, 1);
		rd(8'h00, cw(1, 0, 1));
		pin(1, 1);
		alert(0);
		pin(1, 1);
		conv(2'h2);
		pin(0, 1);
		rd(8'h00, cw(0, 1, 1));
		acc(1, 8'h00, cw(0, 0, 0), 1);
		pin(0, 1);
		rd(8'h10, 32'h1);
		rd(8'h14, {16'h0, conv_result});
		$display("test 4 done");
		acc(1, 8'h08, 32'h0000c000, 1);
		conv(2'h0);
		pin(1, 1);
		rd(8'h00, cw(0, 1, 1));
		pin(0, 1);
		$display("test 5 done");
		repeat (2) @(posedge clk_sys);
		conclude();
	end
endmodule
